// ===== verilog/nqsb_core.sv
`timescale 1ns/1ps
`include "nqsb_regs.svh"
module nqsb_core
    import nqsb_pkg::*;
#(
    parameter int SLOTS = 32,
    parameter int SECTOR_WORDS = `NQSB_SECTOR_WORDS,
    parameter int FIFO_DEPTH = `NQSB_FIFO_DEPTH
)(
    input wire logic core_clk,
    input wire logic reset_n,
    // command block from the transport
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] feature_cur,
    input wire logic [7:0] feature_prev,
    input wire logic [7:0] count_cur,
    input wire logic [7:0] count_prev,
    input wire logic [7:0] sector_num_cur,
    input wire logic [7:0] cyl_low_cur,
    input wire logic [7:0] cyl_high_cur,
    // write-buffer data path into the sector buffer
    input wire logic [15:0] wbuf_data,
    input wire logic wbuf_valid,
    // other media reads or writes disturb the buffer region
    input wire logic media_access,
    input wire logic [15:0] media_data,
    // set-features engine
    output logic setfeat_valid,
    output logic [15:0] setfeat_feature,
    output logic [27:0] setfeat_lba,
    input wire logic setfeat_done,
    input wire logic setfeat_error,
    input wire logic [7:0] setfeat_err_code,
    // queued completion notification
    output logic notify_valid,
    output logic notify_interrupt,
    output logic [SLOTS-1:0] outstanding_cmd_flags,
    input wire logic notify_ack,
    // sector data out to host
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic rd_dma,
    input wire logic rd_ready,
    // taskfile registers
    output logic [7:0] error_report,
    output logic [7:0] device_status
);
    localparam int WW = $clog2(SECTOR_WORDS);
    localparam int SW = $clog2(SLOTS);

    logic [15:0] sector_buf [SECTOR_WORDS];
    nqsb_state_type state, next_state;
    logic [WW-1:0] wr_idx, next_wr_idx, rd_idx, next_rd_idx;
    logic [WW:0] sent, next_sent;
    logic dma_mode, next_dma_mode;
    logic [SW-1:0] slot, next_slot;
    logic [SLOTS-1:0] next_flags;
    logic next_notify_valid;
    logic next_setfeat_valid;
    logic [15:0] next_setfeat_feature;
    logic [27:0] next_setfeat_lba;
    logic [7:0] next_error_report, next_device_status;
    logic push_valid, push_ready;
    logic buf_we;
    logic [15:0] buf_wdata;

    // ----------------------------------------
    // sector buffer
    // ----------------------------------------
    // media traffic reuses the same region, so contents may drift
    always_comb
    begin
        buf_we = wbuf_valid || media_access;
        buf_wdata = wbuf_valid ? wbuf_data : media_data;
    end

    always_ff @(posedge core_clk)
    begin
        if (buf_we)
        begin
            sector_buf[wr_idx] <= buf_wdata;
        end
    end

    // ----------------------------------------
    // command state machine
    // ----------------------------------------
    always_comb
    begin
        next_state = state;
        next_wr_idx = buf_we ? wr_idx + 1'b1 : wr_idx;
        next_rd_idx = rd_idx;
        next_sent = sent;
        next_dma_mode = dma_mode;
        next_slot = slot;
        next_flags = outstanding_cmd_flags;
        next_notify_valid = notify_valid;
        next_setfeat_valid = 1'b0;
        next_setfeat_feature = setfeat_feature;
        next_setfeat_lba = setfeat_lba;
        next_error_report = error_report;
        next_device_status = device_status;
        push_valid = 1'b0;
        // notification taken: start a fresh batch of completions
        if (notify_valid && notify_ack)
        begin
            next_notify_valid = 1'b0;
            next_flags = '0;
        end
        // completions are taken in every state so none is dropped; set wins over the ack
        if (setfeat_done)
        begin
            next_flags[slot] = 1'b1;
            next_notify_valid = 1'b1;
        end
        case (state)
            NQSB_IDLE:
            begin
                if (cmd_valid)
                begin
                    next_device_status[`NQSB_ST_OCCUPIED] = 1'b1;
                    next_device_status[`NQSB_ST_ERR] = 1'b0;
                    next_error_report = `NQSB_ZERO8;
                    if (cmd_code == `NQSB_CMD_WRITE_BUF)
                    begin
                        next_wr_idx = '0; // region restarts at the base
                        next_state = NQSB_DONE;
                    end
                    else if (cmd_code == `NQSB_CMD_READ_BUF || cmd_code == `NQSB_CMD_READ_BUF_DMA)
                    begin
                        next_rd_idx = '0; // same base the write-buffer filled
                        next_sent = '0;
                        next_dma_mode = (cmd_code == `NQSB_CMD_READ_BUF_DMA);
                        next_device_status[`NQSB_ST_XFER] = 1'b1;
                        next_state = NQSB_XFER;
                    end
                    else if (cmd_code == `NQSB_CMD_QUEUED_ND)
                    begin
                        next_slot = SW'(count_cur[`NQSB_SLOT_MSB:`NQSB_SLOT_LSB]);
                        if (feature_cur[`NQSB_SUB_MSB:`NQSB_SUB_LSB] == `NQSB_SUB_SETFEAT)
                        begin
                            next_setfeat_valid = 1'b1;
                            next_setfeat_feature = {feature_prev, feature_cur};
                            next_setfeat_lba = {sector_num_cur[`NQSB_LBA_TOP_MSB:`NQSB_LBA_TOP_LSB],
                                                cyl_high_cur, cyl_low_cur, count_prev};
                            // queued: release the taskfile at once
                            next_device_status[`NQSB_ST_OCCUPIED] = 1'b0;
                            next_state = NQSB_DONE;
                        end
                        else
                        begin
                            next_error_report = `NQSB_ZERO8;
                            next_error_report[`NQSB_ER_REFUSED] = 1'b1;
                            next_state = NQSB_FAIL;
                        end
                    end
                    else
                    begin
                        next_error_report[`NQSB_ER_REFUSED] = 1'b1;
                        next_state = NQSB_FAIL;
                    end
                end
                else if (setfeat_done && setfeat_error)
                begin
                    // engine error lands in the taskfile; a new command takes precedence
                    next_error_report = setfeat_err_code;
                    next_device_status[`NQSB_ST_ERR] = 1'b1;
                end
            end
            NQSB_XFER:
            begin
                push_valid = 1'b1; // one 16-bit word per push
                if (push_ready)
                begin
                    next_rd_idx = rd_idx + 1'b1;
                    next_sent = sent + 1'b1;
                    if (sent == (WW+1)'(SECTOR_WORDS - 1)) // exactly one sector
                    begin
                        next_device_status[`NQSB_ST_XFER] = 1'b0;
                        next_state = NQSB_DONE;
                    end
                end
            end
            NQSB_DONE:
            begin
                // success: fault and error cleared, error byte zero
                next_device_status[`NQSB_ST_OCCUPIED] = 1'b0;
                next_device_status[`NQSB_ST_FAULT] = 1'b0;
                next_device_status[`NQSB_ST_ERR] = 1'b0;
                next_state = NQSB_IDLE;
            end
            NQSB_FAIL:
            begin
                // error before release: err set, occupied cleared
                next_device_status[`NQSB_ST_OCCUPIED] = 1'b0;
                next_device_status[`NQSB_ST_ERR] = 1'b1;
                next_device_status[`NQSB_ST_XFER] = 1'b0;
                next_state = NQSB_IDLE;
            end
            default:
            begin
                next_state = NQSB_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            state <= NQSB_IDLE;
            wr_idx <= '0;
            rd_idx <= '0;
            sent <= '0;
            dma_mode <= 1'b0;
            slot <= '0;
            outstanding_cmd_flags <= '0;
            notify_valid <= 1'b0;
            setfeat_valid <= 1'b0;
            setfeat_feature <= '0;
            setfeat_lba <= '0;
            error_report <= `NQSB_ZERO8;
            device_status <= `NQSB_STATUS_RESET;
        end
        else
        begin
            state <= next_state;
            wr_idx <= next_wr_idx;
            rd_idx <= next_rd_idx;
            sent <= next_sent;
            dma_mode <= next_dma_mode;
            slot <= next_slot;
            outstanding_cmd_flags <= next_flags;
            notify_valid <= next_notify_valid;
            setfeat_valid <= next_setfeat_valid;
            setfeat_feature <= next_setfeat_feature;
            setfeat_lba <= next_setfeat_lba;
            error_report <= next_error_report;
            device_status <= next_device_status;
        end
    end

    // interrupt bit always set on a completion notice
    assign notify_interrupt = notify_valid;
    assign rd_dma = dma_mode;

    // ----------------------------------------
    // outbound word fifo
    // ----------------------------------------
    // decouples the buffer read from host pacing; host stalls push back
    nqsb_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .in_data(sector_buf[rd_idx]),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .out_data(rd_data),
        .out_valid(rd_valid),
        .out_ready(rd_ready)
    );
endmodule // nqsb_core

// ===== verilog/nqsb_regs.svh
// How it works
// - queued non-data command with feature low nibble 5h is a set-features request.
// - previous feature byte gives set-features feature bits 15:8.
// - lba 7:0 prev count, 27:24 sector num, 15:8 cyl low, 23:16 cyl high.
// - successful queued completions raise notify with interrupt and one flag per slot.
// - success report clears fault flag in status and gives zero error byte.
// - error while occupied reports err flag set, occupied clear, error code.
// - command E4h moves exactly one sector from the sector buffer.
// - buffer read delivers the sector as successive 16-bit words.
// - buffer read returns the region the last write-buffer command filled.
// - contents may differ after other reads or writes since the write-buffer.
// - command E9h returns one sector as a dma data phase.
`ifndef NQSB_REGS_SVH
`define NQSB_REGS_SVH
`define NQSB_CMD_QUEUED_ND 8'h63
`define NQSB_CMD_READ_BUF 8'he4
`define NQSB_CMD_READ_BUF_DMA 8'he9
`define NQSB_CMD_WRITE_BUF 8'he8
`define NQSB_SUB_SETFEAT 4'h5
`define NQSB_SUB_LSB 0
`define NQSB_SUB_MSB 3
`define NQSB_SLOT_LSB 3
`define NQSB_SLOT_MSB 7
// status byte bit positions
`define NQSB_ST_OCCUPIED 7
`define NQSB_ST_READY 6
`define NQSB_ST_FAULT 5
`define NQSB_ST_SEEKDONE 4
`define NQSB_ST_XFER 3
`define NQSB_ST_ERR 0
// error byte bit positions
`define NQSB_ER_UNFIX 6
`define NQSB_ER_MISSING 4
`define NQSB_ER_REFUSED 2
`define NQSB_SECTOR_WORDS 256
`define NQSB_FIFO_DEPTH 4
`define NQSB_ZERO8 8'h00
// status after reset: ready and seek complete
`define NQSB_STATUS_RESET 8'h50
// embedded lba bits 27:24 sit in the low nibble of the sector number byte
`define NQSB_LBA_TOP_MSB 3
`define NQSB_LBA_TOP_LSB 0
`endif

// ===== verilog/nqsb_pkg.sv
package nqsb_pkg;
    typedef enum logic [2:0] {
        NQSB_IDLE = 3'b000,
        NQSB_XFER = 3'b001,
        NQSB_DONE = 3'b010,
        NQSB_FAIL = 3'b011
    } nqsb_state_type;
endpackage

// ===== verilog/nqsb_fifo.sv
`timescale 1ns/1ps
module nqsb_fifo
    import nqsb_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
)(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    // ----------------------------------------
    // pointer and count update
    // ----------------------------------------
    always_comb
    begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage has no reset; entries are only read once written
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule // nqsb_fifo

// ===== tb/nqsb_core_checker.sv
`timescale 1ns/1ps
module nqsb_core_checker
    import nqsb_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] feature_cur,
    input wire logic [7:0] feature_prev,
    input wire logic [7:0] count_prev,
    input wire logic [7:0] sector_num_cur,
    input wire logic [7:0] cyl_low_cur,
    input wire logic [7:0] cyl_high_cur,
    input wire logic setfeat_valid,
    input wire logic [15:0] setfeat_feature,
    input wire logic [27:0] setfeat_lba,
    input wire logic notify_valid,
    input wire logic notify_interrupt,
    input wire logic notify_ack,
    input wire logic rd_dma,
    input wire logic [7:0] error_report,
    input wire logic [7:0] device_status
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // a command only counts while the device is not occupied
    logic go;
    assign go = cmd_valid && !device_status[7];
    a_setfeat_field: assert property (go && cmd_code == 8'h63 && feature_cur[3:0] == 4'h5
        |=> setfeat_valid && setfeat_feature == {$past(feature_prev), $past(feature_cur)})
        else $error("set-features feature field wrong");
    a_setfeat_lba: assert property (go && cmd_code == 8'h63 && feature_cur[3:0] == 4'h5
        |=> setfeat_lba == {$past(sector_num_cur[3:0]), $past(cyl_high_cur), $past(cyl_low_cur), $past(count_prev)})
        else $error("set-features lba wrong");
    a_sub_refused: assert property (go && cmd_code == 8'h63 && feature_cur[3:0] != 4'h5
        |=> ##1 error_report[2] && device_status[0] && !device_status[7])
        else $error("unsupported subcommand not refused");
    a_read_busy: assert property (go && cmd_code == 8'he4 |=> device_status == 8'hd8 && !rd_dma)
        else $error("buffer read not started");
    a_dma_phase: assert property (go && cmd_code == 8'he9 |=> rd_dma)
        else $error("dma buffer read not flagged");
    a_notify_hold: assert property (notify_valid && !notify_ack |=> notify_valid && notify_interrupt)
        else $error("notification dropped early");
    a_success_clean: assert property ($rose(notify_valid) |-> device_status[5:0] == 6'h10 && error_report == 8'h00)
        else $error("success report not clean");
    a_fault_report: assert property (device_status[0] |-> !device_status[7] && error_report != 8'h00)
        else $error("fault reported while occupied");
endmodule // nqsb_core_checker
bind nqsb_core nqsb_core_checker u_chk (.*);

// ===== tb/nqsb_host_model.sv
`timescale 1ns/1ps
module nqsb_host_model
    import nqsb_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic setfeat_valid,
    output logic setfeat_done,
    output logic rd_ready
);
    logic [3:0] tick;
    logic [2:0] wait_cnt;
    // free tick for stalls, countdown for the slow feature engine
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            tick <= 4'h0;
            wait_cnt <= 3'h0;
        end
        else
        begin
            tick <= tick + 4'h1;
            wait_cnt <= setfeat_valid ? 3'h4 : wait_cnt - {2'h0, wait_cnt != 3'h0};
        end
    end
    // four-cycle stall in sixteen, long enough to fill the fifo
    assign rd_ready = reset_n && tick[3:2] != 2'h0;
    assign setfeat_done = wait_cnt == 3'h1;
endmodule // nqsb_host_model

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import nqsb_pkg::*;
    localparam int WORDS = 8;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [7:0] tf [8] = '{default: 8'h00};
    logic [15:0] wbuf_data = 16'h0000, media_data = 16'h0000;
    logic wbuf_valid = 1'b0, media_access = 1'b0, notify_ack = 1'b0;
    logic setfeat_valid, setfeat_done, notify_valid, notify_interrupt, rd_valid, rd_dma, rd_ready;
    logic [15:0] setfeat_feature, rd_data;
    logic [27:0] setfeat_lba;
    logic [31:0] outstanding_cmd_flags;
    logic [7:0] error_report, device_status;
    logic [15:0] got [$];
    int err_total = 0, cmp_count = 0, ticks = 0;
    logic [7:0] bad [3] = '{8'h00, 8'h01, 8'h0f};

    always #50 core_clk = ~core_clk;

    nqsb_core #(.SECTOR_WORDS(WORDS)) u_nqsb_core (.core_clk(core_clk), .reset_n(reset_n),
        .cmd_valid(cmd_valid), .cmd_code(tf[0]), .feature_cur(tf[1]), .feature_prev(tf[2]),
        .count_cur(tf[3]), .count_prev(tf[4]), .sector_num_cur(tf[5]), .cyl_low_cur(tf[6]),
        .cyl_high_cur(tf[7]), .wbuf_data(wbuf_data), .wbuf_valid(wbuf_valid),
        .media_access(media_access), .media_data(media_data), .setfeat_valid(setfeat_valid),
        .setfeat_feature(setfeat_feature), .setfeat_lba(setfeat_lba), .setfeat_done(setfeat_done),
        .setfeat_error(1'b0), .setfeat_err_code(8'h00), .notify_valid(notify_valid),
        .notify_interrupt(notify_interrupt), .outstanding_cmd_flags(outstanding_cmd_flags),
        .notify_ack(notify_ack), .rd_data(rd_data), .rd_valid(rd_valid), .rd_dma(rd_dma),
        .rd_ready(rd_ready), .error_report(error_report), .device_status(device_status));

    nqsb_host_model u_host (.core_clk(core_clk), .reset_n(reset_n), .setfeat_valid(setfeat_valid),
        .setfeat_done(setfeat_done), .rd_ready(rd_ready));

    // collect every word the host accepts
    always @(posedge core_clk)
        if (rd_valid && rd_ready)
            got.push_back(rd_data);

    // hang guard, well above the hundred or so cycles the run needs
    always @(posedge core_clk)
    begin
        ticks++;
        if (ticks == 20000)
        begin
            err_total++;
            test_done();
        end
    end

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h want %h", $time, seen, want);
        end
    endtask

    // one-cycle command pulse with its taskfile bytes
    task automatic issue(input logic [7:0] c, f, fp, cc, cp, sn, cl, ch);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        tf <= '{c, f, fp, cc, cp, sn, cl, ch};
        @(posedge core_clk);
        cmd_valid <= 1'b0;
    endtask

    task automatic wait_idle();
        int n;
        #1;
        for (n = 0; n < 500 && device_status[7] !== 1'b0; n++)
        begin
            @(posedge core_clk);
            #1;
        end
    endtask

    task automatic wr_buf(input logic [15:0] base);
        int n;
        issue(8'he8, 0, 0, 0, 0, 0, 0, 0);
        wait_idle();
        for (n = 0; n < WORDS; n++)
        begin
            @(posedge core_clk);
            wbuf_valid <= 1'b1;
            wbuf_data <= base + n[15:0];
        end
        @(posedge core_clk);
        wbuf_valid <= 1'b0;
    endtask

    task automatic rd_buf(input logic [7:0] op, input logic [15:0] base);
        int n;
        got.delete();
        issue(op, 0, 0, 0, 0, 0, 0, 0);
        #1;
        chk(device_status, 8'hd8);
        for (n = 0; n < 400 && got.size() < WORDS; n++)
            @(posedge core_clk);
        wait_idle();
        chk(got.size(), WORDS);
        chk(rd_dma, op == 8'he9);
        for (n = 0; n < WORDS; n++)
            chk(got[n], base + n[15:0]);
    endtask

    initial
    begin
        int n;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        #1;
        chk(device_status, 8'h50);
        // unknown opcode is aborted while occupied
        issue(8'h5a, 0, 0, 0, 0, 0, 0, 0);
        wait_idle();
        chk(error_report, 8'h04);
        chk({device_status[7], device_status[0]}, 2'b01);
        wr_buf(16'h1200);
        rd_buf(8'he4, 16'h1200);
        rd_buf(8'he9, 16'h1200);
        // stray media traffic, then a fresh fill must win
        @(posedge core_clk);
        media_access <= 1'b1;
        media_data <= 16'hdead;
        repeat (3) @(posedge core_clk);
        media_access <= 1'b0;
        wr_buf(16'h7700);
        rd_buf(8'he4, 16'h7700);
        // set-features in slot 3
        issue(8'h63, 8'ha5, 8'h3c, 8'h18, 8'h9b, 8'hf4, 8'h56, 8'h78);
        #1;
        chk(setfeat_valid, 1);
        chk(setfeat_feature, 16'h3ca5);
        chk(setfeat_lba, 28'h478569b);
        for (n = 0; n < 50 && notify_valid !== 1'b1; n++)
            @(posedge core_clk);
        #1;
        chk(outstanding_cmd_flags, 32'h8);
        chk(notify_interrupt, 1);
        chk({device_status[5], device_status[0], error_report}, 0);
        @(posedge core_clk);
        notify_ack <= 1'b1;
        @(posedge core_clk);
        notify_ack <= 1'b0;
        #1;
        chk(outstanding_cmd_flags, 0);
        // unsupported subcommands, each waited out to idle before the next
        foreach (bad[i])
        begin
            issue(8'h63, bad[i], 0, 8'h20, 0, 0, 0, 0);
            wait_idle();
            chk(error_report[2], 1);
            chk({device_status[7], device_status[0]}, 2'b01);
        end
        test_done();
    end
endmodule // testbench
